/* File: rtl/switch_mc_defs.vh */
`ifndef SWITCH_MC_DEFS_VH
`define SWITCH_MC_DEFS_VH
// Command codes delivered by the tokenizer
`define CMD_ALARM_QUERY 5'h00
`define CMD_AUTO 5'h01
`define CMD_BAUD 5'h02
`define CMD_PW_CLEAR 5'h03
`define CMD_SCREEN_WIPE 5'h04
`define CMD_LINE_END 5'h05
`define CMD_REPEAT 5'h06
`define CMD_PORT_CFG 5'h07
`define CMD_ECHO 5'h08
`define CMD_TITLE 5'h09
`define CMD_LOCK 5'h0A
`define CMD_MODE_QUERY 5'h0B
`define CMD_MODEM 5'h0C
`define CMD_MODEM_TEXT 5'h0D
`define CMD_DIRECT 5'h0E
`define CMD_RESTART 5'h0F
`define CMD_RX_ONE 5'h10
`define CMD_RX_TWO 5'h11
`define CMD_SAVE 5'h12
`define CMD_PW_SET 5'h13
`define CMD_STANDBY 5'h14
`define CMD_TX_ONE 5'h15
`define CMD_TX_TWO 5'h16
`define CMD_UNLOCK 5'h17
`define CMD_PKT_MODE 5'h18
`define CMD_TERM_MODE 5'h19
`define CMD_NONE 5'h1F
// Alarm bit positions
`define ALM_RX_ONE 0
`define ALM_RX_TWO 1
`define ALM_TX_ONE 2
`define ALM_TX_TWO 3
`define ALM_RELAY 4
`define ALM_NVM 5
// Serial settings
`define BAUD_MAX 3'h7
`define BAUD_RST 3'h4
`define PKT_RST 2'h1
`define ECHO_RST 2'h3
// Text limits
`define TITLE_MAX 6'h20
`define MODEM_MAX 6'h28
`define PW_MIN 4'h4
`define PW_MAX 4'h8
`define WIPE_LINES 5'h19
`define CHR_LF 8'h0A
`define CHR_CR 8'h0D
// Timing
`define CLK_HZ 40000000
`define ALARM_RATE_HZ 10
`define MODEM_PERIOD_MS 10000
`endif

/* File: rtl/switch_mc.v */
`include "switch_mc_defs.vh"

module switch_mc #(
    parameter DEPTH = 4,
    parameter TICK_CYCLES = `CLK_HZ / `ALARM_RATE_HZ,
    parameter MODEM_CYCLES = `CLK_HZ / 1000 * `MODEM_PERIOD_MS,
    parameter MODEM_PORT = 1
) (
    input wire clk,
    input wire resetn,
    input wire cmd_valid,
    input wire [4:0] cmd_code,
    input wire cmd_port,
    input wire cmd_target,
    input wire [4:0] cmd_sub,
    input wire cmd_has_arg,
    input wire [7:0] cmd_arg,
    input wire [3:0] cmd_text_len,
    input wire [63:0] cmd_text,
    input wire [63:0] cmd_text2,
    input wire cmd_eol,
    output reg cmd_ready,
    input wire str_we,
    input wire str_sel,
    input wire [5:0] str_idx,
    input wire [7:0] str_char,
    input wire [4:0] title_idx,
    output reg [7:0] title_char,
    output reg [5:0] title_len,
    output reg resp_valid,
    output reg [4:0] resp_code,
    output reg resp_ok,
    output reg [15:0] resp_data,
    input wire recv_side_one_fault,
    input wire recv_side_two_fault,
    input wire xmit_side_one_fault,
    input wire xmit_side_two_fault,
    input wire tx_relay_conf,
    input wire rx_relay_conf,
    input wire nvm_write_fail,
    input wire nvm_erase_fail,
    input wire nvm_done_ok,
    output reg [5:0] alarms,
    output reg tx_relay_sel,
    output reg rx_relay_sel,
    output reg tx_manual,
    output reg rx_manual,
    output reg [1:0] xmit_mute_line,
    output reg [5:0] baud_sel,
    output reg [1:0] echo_en,
    output reg [1:0] line_ending_insert,
    output reg [1:0] packet_mode,
    output reg packet_repeat_enable,
    output reg locked,
    output reg modem_mode,
    output reg pkt_gen_enable,
    output reg mc_restart,
    output reg nvm_save,
    output reg [12:0] nvm_save_data,
    input wire carrier_detect_input,
    input wire disp_valid,
    input wire disp_port,
    input wire [7:0] disp_char,
    output reg disp_ready,
    input wire tx_ready,
    output reg tx_valid,
    output reg tx_port,
    output reg [7:0] tx_char,
    input wire [1:0] pkt_in_valid,
    input wire [15:0] pkt_in_byte,
    output reg [1:0] pkt_rep_valid,
    output reg [15:0] pkt_rep_byte
);

localparam EW = 153;
localparam S_IDLE = 3'h0;
localparam S_WIPE = 3'h1;
localparam S_DISP = 3'h2;
localparam S_LF = 3'h3;
localparam S_MODEM = 3'h4;

// Every byte of the first n bytes is a letter or digit
function pw_ok;
    input [63:0] t;
    input [3:0] n;
    integer i;
    reg [7:0] c;
    begin
        pw_ok = 1'b1;
        for (i = 0; i < 8; i = i + 1) begin
            c = t[8*i +: 8];
            if (i < n && !((c >= 8'h30 && c <= 8'h39) ||
                (c >= 8'h41 && c <= 8'h5A) || (c >= 8'h61 && c <= 8'h7A)))
                pw_ok = 1'b0;
        end
    end
endfunction

reg [EW-1:0] q_mem [0:DEPTH-1];
reg [7:0] title_mem [0:31];
reg [7:0] modem_mem [0:39];
reg [3:0] q_cnt_q, q_rd_q;
reg exec_q, ovf_q;
reg [31:0] tick_cnt_q, modem_cnt_q;
reg nvm_fail_q, pw_set_q, warm_q, modem_due_q, wipe_pend_q, wipe_port_q;
reg [63:0] pw_q;
reg [5:0] modem_len_q, pos_q;
reg [2:0] st_q;

wire [EW-1:0] ent = q_mem[q_rd_q[1:0] % DEPTH];
wire [4:0] e_code = ent[152:148];
wire e_port = ent[147];
wire e_tgt = ent[146];
wire [4:0] e_sub = ent[145:141];
wire e_has = ent[140];
wire [7:0] e_arg = ent[139:132];
wire [3:0] e_len = ent[131:128];
wire [63:0] e_txt = ent[127:64];
wire [63:0] e_txt2 = ent[63:0];
wire cfg = (e_code == `CMD_PORT_CFG);
wire tp = cfg ? e_tgt : e_port;
wire [4:0] op = cfg ? e_sub : e_code;
wire lock_ok = !locked || e_code == `CMD_UNLOCK ||
    e_code == `CMD_SCREEN_WIPE || e_code == `CMD_ALARM_QUERY;
wire tick = (tick_cnt_q == TICK_CYCLES - 1);
wire link_up = !modem_mode || carrier_detect_input;

////////////////////////////////////////////////////////////////////////
// Strings are written straight into their arrays; length commits them
always @(posedge clk) begin
    if (str_we && !str_sel && str_idx < `TITLE_MAX)
        title_mem[str_idx[4:0]] <= str_char;
    if (str_we && str_sel && str_idx < `MODEM_MAX)
        modem_mem[str_idx] <= str_char;
    if (cmd_valid && cmd_ready && q_cnt_q < DEPTH)
        q_mem[q_cnt_q[1:0] % DEPTH] <= {cmd_code, cmd_port, cmd_target,
            cmd_sub, cmd_has_arg, cmd_arg, cmd_text_len, cmd_text, cmd_text2};
end

////////////////////////////////////////////////////////////////////////
// Command queue, execution, alarms and relays
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        q_cnt_q <= 4'h0; q_rd_q <= 4'h0; exec_q <= 1'b0; ovf_q <= 1'b0;
        cmd_ready <= 1'b0; resp_valid <= 1'b0; resp_code <= `CMD_NONE;
        resp_ok <= 1'b0; resp_data <= 16'h0000; tick_cnt_q <= 32'h0;
        alarms <= 6'h00; nvm_fail_q <= 1'b0; tx_relay_sel <= 1'b0;
        rx_relay_sel <= 1'b0; tx_manual <= 1'b0; rx_manual <= 1'b0;
        baud_sel <= {2{`BAUD_RST}}; echo_en <= `ECHO_RST;
        line_ending_insert <= 2'h0; packet_mode <= `PKT_RST;
        packet_repeat_enable <= 1'b0; locked <= 1'b0; pw_set_q <= 1'b0;
        pw_q <= 64'h0; modem_mode <= 1'b0; warm_q <= 1'b0;
        mc_restart <= 1'b0; nvm_save <= 1'b0; nvm_save_data <= 13'h0000;
        title_len <= 6'h00; modem_len_q <= 6'h00; wipe_pend_q <= 1'b0;
        wipe_port_q <= 1'b0; xmit_mute_line <= 2'h0; pkt_gen_enable <= 1'b0;
    end else begin
        resp_valid <= 1'b0;
        mc_restart <= 1'b0;
        nvm_save <= 1'b0;
        cmd_ready <= !exec_q && !(cmd_valid && cmd_ready && cmd_eol);
        tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
        if (nvm_write_fail || nvm_erase_fail)
            nvm_fail_q <= 1'b1;
        else if (nvm_done_ok)
            nvm_fail_q <= 1'b0;
        if (tick) begin
            alarms[`ALM_RX_ONE] <= recv_side_one_fault;
            alarms[`ALM_RX_TWO] <= recv_side_two_fault;
            alarms[`ALM_TX_ONE] <= xmit_side_one_fault;
            alarms[`ALM_TX_TWO] <= xmit_side_two_fault;
            alarms[`ALM_RELAY] <= (tx_relay_conf != tx_relay_sel) ||
                (rx_relay_conf != rx_relay_sel);
            alarms[`ALM_NVM] <= nvm_fail_q;
            if (!tx_manual && (tx_relay_sel ? xmit_side_two_fault &&
                !xmit_side_one_fault : xmit_side_one_fault &&
                !xmit_side_two_fault))
                tx_relay_sel <= !tx_relay_sel;
            if (!rx_manual && (rx_relay_sel ? recv_side_two_fault &&
                !recv_side_one_fault : recv_side_one_fault &&
                !recv_side_two_fault))
                rx_relay_sel <= !rx_relay_sel;
        end
        // mute the side not on line when warm
        xmit_mute_line <= warm_q ? (tx_relay_sel ? 2'h1 : 2'h2) : 2'h0;
        pkt_gen_enable <= link_up;
        if (wipe_pend_q && st_q == S_IDLE && (!tx_valid || tx_ready))
            wipe_pend_q <= 1'b0;
        if (cmd_valid && cmd_ready) begin
            if (q_cnt_q < DEPTH)
                q_cnt_q <= q_cnt_q + 4'h1;
            else
                ovf_q <= 1'b1;
            if (cmd_eol)
                exec_q <= 1'b1;
        end
        if (exec_q) begin
            q_rd_q <= q_rd_q + 4'h1;
            if (q_rd_q + 4'h1 >= q_cnt_q || ovf_q) begin
                exec_q <= 1'b0; q_cnt_q <= 4'h0; q_rd_q <= 4'h0;
                ovf_q <= 1'b0;
            end
            resp_valid <= 1'b1;
            resp_code <= ovf_q ? `CMD_NONE : e_code;
            resp_ok <= 1'b0;
            resp_data <= 16'h0000;
            if (ovf_q || !lock_ok) begin
                resp_ok <= 1'b0;
            end else case (op)
            `CMD_ALARM_QUERY: begin
                resp_ok <= 1'b1;
                resp_data <= {7'h00, alarms == 6'h00, 2'h0, alarms};
            end
            `CMD_AUTO: begin
                tx_manual <= 1'b0; rx_manual <= 1'b0; resp_ok <= 1'b1;
            end
            `CMD_RX_ONE, `CMD_RX_TWO: begin
                rx_relay_sel <= (op == `CMD_RX_TWO); rx_manual <= 1'b1;
                resp_ok <= 1'b1; resp_data <= {15'h0000, op == `CMD_RX_TWO};
            end
            `CMD_TX_ONE, `CMD_TX_TWO: begin
                tx_relay_sel <= (op == `CMD_TX_TWO); tx_manual <= 1'b1;
                resp_ok <= 1'b1; resp_data <= {15'h0000, op == `CMD_TX_TWO};
            end
            `CMD_BAUD: begin
                if (e_has && e_arg <= {5'h00, `BAUD_MAX}) begin
                    baud_sel[3*tp +: 3] <= e_arg[2:0];
                    resp_ok <= 1'b1;
                end
                resp_data <= {13'h0000, e_has && e_arg <= 8'h07 ?
                    e_arg[2:0] : baud_sel[3*tp +: 3]};
            end
            `CMD_ECHO, `CMD_LINE_END: begin
                if (e_has && e_arg[7:1] == 7'h00) begin
                    if (op == `CMD_ECHO) echo_en[tp] <= e_arg[0];
                    else line_ending_insert[tp] <= e_arg[0];
                end
                resp_ok <= e_arg[7:1] == 7'h00 || !e_has;
                resp_data <= {15'h0000, e_has ? e_arg[0] :
                    (op == `CMD_ECHO ? echo_en[tp] : line_ending_insert[tp])};
            end
            `CMD_PKT_MODE, `CMD_TERM_MODE: begin
                packet_mode[tp] <= (op == `CMD_PKT_MODE); resp_ok <= 1'b1;
            end
            `CMD_NONE: begin
                resp_ok <= cfg;
                resp_data <= {4'h0, packet_mode[1], line_ending_insert[1],
                    echo_en[1], baud_sel[5:3], packet_mode[0],
                    line_ending_insert[0], echo_en[0], baud_sel[2:0]};
            end
            `CMD_REPEAT: begin
                if (e_has) packet_repeat_enable <= e_arg[0];
                resp_ok <= 1'b1;
                resp_data <= {15'h0000, e_has ? e_arg[0] :
                    packet_repeat_enable};
            end
            `CMD_SCREEN_WIPE: begin
                if (!packet_mode[e_port]) begin
                    wipe_pend_q <= 1'b1; wipe_port_q <= e_port;
                end
                resp_ok <= 1'b1;
            end
            `CMD_TITLE: begin
                if (!e_has || e_arg <= {2'h0, `TITLE_MAX}) begin
                    title_len <= e_has ? e_arg[5:0] : 6'h00;
                    resp_ok <= 1'b1;
                end
            end
            `CMD_MODEM_TEXT: begin
                if (e_has && e_arg <= {2'h0, `MODEM_MAX}) begin
                    modem_len_q <= e_arg[5:0]; resp_ok <= 1'b1;
                end
                resp_data <= {10'h000, modem_len_q};
            end
            `CMD_LOCK: begin
                if (!pw_set_q || (e_txt == pw_q && e_len != 4'h0)) begin
                    locked <= 1'b1; resp_ok <= 1'b1;
                end
            end
            `CMD_UNLOCK: begin
                if (!pw_set_q || e_txt == pw_q) begin
                    locked <= 1'b0; resp_ok <= 1'b1;
                end
            end
            `CMD_PW_CLEAR: begin
                if (pw_set_q && e_txt == pw_q) begin
                    pw_set_q <= 1'b0; pw_q <= 64'h0; resp_ok <= 1'b1;
                end
            end
            `CMD_PW_SET: begin
                if (!pw_set_q && e_len >= `PW_MIN && e_len <= `PW_MAX &&
                    e_txt == e_txt2 && pw_ok(e_txt, e_len)) begin
                    pw_set_q <= 1'b1; pw_q <= e_txt; resp_ok <= 1'b1;
                end
            end
            `CMD_MODEM, `CMD_DIRECT: begin
                modem_mode <= (op == `CMD_MODEM); resp_ok <= 1'b1;
            end
            `CMD_MODE_QUERY: begin
                resp_ok <= 1'b1; resp_data <= {15'h0000, modem_mode};
            end
            `CMD_STANDBY: begin
                if (e_has && e_arg[7:1] == 7'h00) warm_q <= e_arg[0];
                resp_ok <= !e_has || e_arg[7:1] == 7'h00;
                resp_data <= {15'h0000, e_has ? e_arg[0] : warm_q};
            end
            `CMD_RESTART: begin
                mc_restart <= 1'b1; resp_ok <= 1'b1;
            end
            `CMD_SAVE: begin
                nvm_save <= 1'b1; resp_ok <= 1'b1;
                nvm_save_data <= {warm_q, packet_mode, line_ending_insert,
                    echo_en, baud_sel};
            end
            default: begin
                resp_ok <= 1'b0; resp_data <= {11'h000, e_code};
            end
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Character output: wipe, display with line-ending insert, modem text
// format is fixed downstream; no format control exists here
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        st_q <= S_IDLE; pos_q <= 6'h00; tx_valid <= 1'b0; tx_port <= 1'b0;
        tx_char <= 8'h00; disp_ready <= 1'b0; modem_cnt_q <= 32'h0;
        modem_due_q <= 1'b0; title_char <= 8'h00;
        pkt_rep_valid <= 2'h0; pkt_rep_byte <= 16'h0000;
    end else begin
        title_char <= title_mem[title_idx];
        modem_cnt_q <= (modem_cnt_q == MODEM_CYCLES - 1) ? 32'h0 :
            modem_cnt_q + 32'h1;
        if (modem_mode && modem_cnt_q == MODEM_CYCLES - 1 &&
            modem_len_q != 6'h00)
            modem_due_q <= 1'b1;
        else if (st_q == S_MODEM)
            modem_due_q <= 1'b0;
        pkt_rep_valid <= {pkt_in_valid[0] & packet_mode[0],
            pkt_in_valid[1] & packet_mode[1]} & {2{packet_repeat_enable}};
        pkt_rep_byte <= {pkt_in_byte[7:0], pkt_in_byte[15:8]};
        disp_ready <= 1'b0;
        if (!tx_valid || tx_ready) begin
            tx_valid <= 1'b0;
            case (st_q)
            S_IDLE: begin
                pos_q <= 6'h00;
                if (wipe_pend_q) begin
                    st_q <= S_WIPE; tx_port <= wipe_port_q;
                end else if (modem_due_q) begin
                    st_q <= S_MODEM; tx_port <= (MODEM_PORT != 0);
                end else if (disp_valid && link_up && !disp_ready) begin
                    disp_ready <= 1'b1; st_q <= S_DISP;
                end
            end
            S_WIPE: begin
                tx_valid <= 1'b1; tx_char <= `CHR_LF;
                pos_q <= pos_q + 6'h01;
                if (pos_q == {1'b0, `WIPE_LINES} - 6'h01) st_q <= S_IDLE;
            end
            S_DISP: begin
                tx_valid <= 1'b1; tx_char <= disp_char; tx_port <= disp_port;
                st_q <= (disp_char == `CHR_CR &&
                    line_ending_insert[disp_port]) ? S_LF : S_IDLE;
            end
            S_LF: begin
                tx_valid <= 1'b1; tx_char <= `CHR_LF; st_q <= S_IDLE;
            end
            S_MODEM: begin
                tx_valid <= 1'b1; tx_char <= modem_mem[pos_q];
                pos_q <= pos_q + 6'h01;
                if (pos_q + 6'h01 >= modem_len_q) st_q <= S_IDLE;
            end
            default: st_q <= S_IDLE;
            endcase
        end
    end
end

endmodule // switch_mc

/* File: tb/switch_mc_sva.sv */
`include "switch_mc_defs.vh"
module switch_mc_sva #(
    parameter TICK_CYCLES = 20
) (
    input wire clk,
    input wire resetn,
    input wire cmd_valid,
    input wire [4:0] cmd_code,
    input wire cmd_eol,
    input wire cmd_ready,
    input wire resp_valid,
    input wire resp_ok,
    input wire recv_side_one_fault,
    input wire nvm_write_fail,
    input wire [5:0] alarms,
    input wire tx_relay_sel,
    input wire rx_relay_sel,
    input wire rx_manual,
    input wire [1:0] xmit_mute_line,
    input wire locked,
    input wire mc_restart
);
    reg [3:0] alm_q;
    reg [31:0] gap_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////
    // Cycles since the transceiver alarms last moved; saturates at a tick
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            alm_q <= 4'h0;
            gap_q <= TICK_CYCLES;
        end else begin
            alm_q <= alarms[3:0];
            if (alarms[3:0] != alm_q)
                gap_q <= 32'h0;
            else if (gap_q < TICK_CYCLES)
                gap_q <= gap_q + 32'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    sequence s_line_taken;
        cmd_valid && cmd_ready && cmd_eol;
    endsequence
    sequence s_answer;
        ##2 resp_valid;
    endsequence
    property p_ready_drops;
        s_line_taken |=> !cmd_ready;
    endproperty
    a_ready_drops: assert property (p_ready_drops)
        else $error("command queue still ready after line end");
    property p_answer;
        s_line_taken |-> s_answer;
    endproperty
    a_answer: assert property (p_answer)
        else $error("no response two cycles after line end");
    property p_lock_refuse;
        locked && cmd_code == `CMD_BAUD |-> s_line_taken |-> s_answer ##0 !resp_ok;
    endproperty
    a_lock_refuse: assert property (p_lock_refuse)
        else $error("locked unit accepted a setting");
    // Idle queue means nothing may move a forced receive relay
    property p_rx_hold;
        rx_manual && cmd_ready && !cmd_valid |=> $stable(rx_relay_sel);
    endproperty
    a_rx_hold: assert property (p_rx_hold)
        else $error("forced receive relay moved");
    property p_mute;
        $stable(tx_relay_sel) |-> !xmit_mute_line[tx_relay_sel];
    endproperty
    a_mute: assert property (p_mute)
        else $error("online transmitter muted");
    property p_tick;
        alarms[3:0] != alm_q |-> gap_q >= TICK_CYCLES - 1;
    endproperty
    a_tick: assert property (p_tick)
        else $error("alarms changed between evaluations");
    property p_alarm_cause;
        $rose(alarms[0]) |-> $past(recv_side_one_fault)
            || $past(recv_side_one_fault, 2);
    endproperty
    a_alarm_cause: assert property (p_alarm_cause)
        else $error("receive alarm without receive fault");
    property p_nvm;
        nvm_write_fail |-> ##[1:64] alarms[5];
    endproperty
    a_nvm: assert property (p_nvm)
        else $error("memory failure not flagged");
    property p_restart;
        mc_restart |-> $stable(tx_relay_sel) && $stable(rx_relay_sel);
    endproperty
    a_restart: assert property (p_restart)
        else $error("relay moved on restart");
endmodule // switch_mc_sva

bind switch_mc switch_mc_sva #(.TICK_CYCLES(TICK_CYCLES)) switch_mc_sva_i (
    .clk, .resetn, .cmd_valid, .cmd_code, .cmd_eol, .cmd_ready,
    .resp_valid, .resp_ok, .recv_side_one_fault, .nvm_write_fail, .alarms,
    .tx_relay_sel, .rx_relay_sel, .rx_manual, .xmit_mute_line, .locked,
    .mc_restart);

/* File: tb/term_model.sv */
module term_model (
    input wire clk,
    input wire resetn,
    input wire slow,
    input wire tx_valid,
    input wire tx_port,
    input wire [7:0] tx_char,
    output reg tx_ready,
    output reg [7:0] lf_count
);
    timeunit 1ns;
    timeprecision 1ps;
    // Terminal takes whole bytes; when slow it stalls every other cycle
    // byte framing
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_ready <= 1'b0;
            lf_count <= 8'h00;
        end else begin
            tx_ready <= slow ? ~tx_ready : 1'b1;
            if (tx_valid && tx_ready && tx_port && tx_char == 8'h0A)
                lf_count <= lf_count + 8'h01;
        end
    end
endmodule // term_model

/* File: tb/tb_top.sv */
`include "switch_mc_defs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK = 20;
    logic clk, resetn, cmd_valid, cmd_port, cmd_eol, cmd_ready, tx_ready;
    logic [4:0] cmd_code;
    logic [7:0] cmd_arg, lf_count, tx_char;
    logic [3:0] flt;
    logic tx_stuck, slow, nvm_write_fail, nvm_erase_fail, nvm_done_ok;
    logic resp_valid, resp_ok, tx_relay_sel, rx_relay_sel, rx_manual;
    logic locked, tx_valid, tx_port;
    logic [15:0] resp_data;
    logic [5:0] alarms, baud_sel;
    logic [1:0] xmit_mute_line;
    logic r_ok;
    logic [15:0] r_data;
    logic cmd_target, cmd_has_arg, str_we, carrier_detect_input, disp_valid;
    logic [4:0] cmd_sub;
    logic [3:0] cmd_text_len;
    logic [63:0] pw;
    logic [5:0] str_idx;
    logic [7:0] str_char, disp_char;
    logic [1:0] pkt_in_valid;
    int fail_count, cmp_count, cyc;
    switch_mc #(.TICK_CYCLES(TICK), .MODEM_CYCLES(50)) switch_mc_i (
        .clk, .resetn, .cmd_valid, .cmd_code, .cmd_port, .cmd_target,
        .cmd_sub, .cmd_has_arg, .cmd_arg, .cmd_text_len, .cmd_text(pw),
        .cmd_text2(pw), .cmd_eol, .cmd_ready, .str_we, .str_sel(1'b0),
        .str_idx, .str_char, .title_idx(5'h00),
        .title_char(), .title_len(), .resp_valid, .resp_code(), .resp_ok,
        .resp_data, .recv_side_one_fault(flt[0]),
        .recv_side_two_fault(flt[1]), .xmit_side_one_fault(flt[2]),
        .xmit_side_two_fault(flt[3]), .tx_relay_conf(tx_relay_sel ^ tx_stuck),
        .rx_relay_conf(rx_relay_sel), .nvm_write_fail, .nvm_erase_fail,
        .nvm_done_ok, .alarms, .tx_relay_sel, .rx_relay_sel, .tx_manual(),
        .rx_manual, .xmit_mute_line, .baud_sel, .echo_en(),
        .line_ending_insert(), .packet_mode(), .packet_repeat_enable(),
        .locked, .modem_mode(), .pkt_gen_enable(), .mc_restart(),
        .nvm_save(), .nvm_save_data(), .carrier_detect_input,
        .disp_valid, .disp_port(1'b0), .disp_char,
        .disp_ready(), .tx_ready, .tx_valid, .tx_port, .tx_char,
        .pkt_in_valid, .pkt_in_byte(16'h0000), .pkt_rep_valid(),
        .pkt_rep_byte());
    term_model term_model_i (.clk, .resetn, .slow, .tx_valid, .tx_port,
        .tx_char, .tx_ready, .lf_count);
    ////////////////////////////////////////////////////////////////////////
    task automatic check(string nm, logic [15:0] exp, logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One-entry line; request held until the queue shows ready
    task automatic cmd(logic [4:0] c, logic p, logic [7:0] a);
        int n;
        @(posedge clk);
        cmd_code <= c;
        cmd_port <= p;
        cmd_arg <= a;
        cmd_eol <= 1'b1;
        cmd_valid <= 1'b1;
        do @(posedge clk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        n = 0;
        while (resp_valid !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        check("response", 16'h1, {15'h0, n < 20});
        r_ok = resp_ok;
        r_data = resp_data;
    endtask
    task automatic settle();
        repeat (3 * TICK) @(posedge clk);
    endtask
    task automatic t_baud();
        check("baud reset", 16'h24, {10'h0, baud_sel});
        cmd(`CMD_BAUD, 1'b1, 8'h07);
        check("baud p1", 16'h3C, {10'h0, baud_sel});
        for (int i = 0; i < 8; i++) begin
            cmd(`CMD_BAUD, 1'b0, i[7:0]);
            check("baud p0", {10'h0, 3'h7, i[2:0]}, {10'h0, baud_sel});
        end
        // Out of range rate must leave the port alone
        cmd(`CMD_BAUD, 1'b1, 8'h08);
        check("bad rate ok", 16'h0, {15'h0, r_ok});
        check("bad rate", 16'h3F, {10'h0, baud_sel});
    endtask
    task automatic t_lock();
        cmd(`CMD_LOCK, 1'b0, 8'h00);
        check("locked", 16'h1, {15'h0, locked});
        cmd(`CMD_BAUD, 1'b0, 8'h01);
        check("locked baud", 16'h3F, {10'h0, baud_sel});
        cmd(`CMD_ALARM_QUERY, 1'b0, 8'h00);
        check("locked query", 16'h1, {15'h0, r_ok});
        cmd(`CMD_UNLOCK, 1'b0, 8'h00);
        check("unlocked", 16'h0, {15'h0, locked});
        // Password set once, refused again, cleared by itself
        pw <= 64'h44434241;
        cmd_text_len <= 4'h4;
        cmd(`CMD_PW_SET, 1'b0, 8'h00);
        check("pw set", 16'h1, {15'h0, r_ok});
        cmd(`CMD_PW_SET, 1'b0, 8'h00);
        check("pw again", 16'h0, {15'h0, r_ok});
        cmd(`CMD_PW_CLEAR, 1'b0, 8'h00);
        check("pw clear", 16'h1, {15'h0, r_ok});
    endtask
    task automatic t_alarms();
        flt <= 4'h5;
        settle();
        check("alarms", 16'h05, {10'h0, alarms});
        cmd(`CMD_ALARM_QUERY, 1'b0, 8'h00);
        check("query", 16'h0005, r_data);
        check("auto moved", 16'h3, {14'h0, tx_relay_sel, rx_relay_sel});
        flt <= 4'h0;
        settle();
        cmd(`CMD_ALARM_QUERY, 1'b0, 8'h00);
        check("all clear", 16'h0100, r_data);
    endtask
    task automatic t_manual();
        cmd(`CMD_RX_ONE, 1'b0, 8'h00);
        cmd(`CMD_TX_ONE, 1'b0, 8'h00);
        flt <= 4'h5;
        settle();
        check("manual rx", 16'h1, {15'h0, rx_manual});
        check("held", 16'h0, {14'h0, tx_relay_sel, rx_relay_sel});
        cmd(`CMD_RESTART, 1'b0, 8'h00);
        check("restart", 16'h0, {14'h0, tx_relay_sel, rx_relay_sel});
        cmd(`CMD_AUTO, 1'b0, 8'h00);
        settle();
        check("auto back", 16'h3, {14'h0, tx_relay_sel, rx_relay_sel});
        flt <= 4'h0;
        tx_stuck <= 1'b1;
        settle();
        check("mismatch", 16'h10, {10'h0, alarms});
        tx_stuck <= 1'b0;
        nvm_write_fail <= 1'b1;
        @(posedge clk) nvm_write_fail <= 1'b0;
        settle();
        check("write fail", 16'h20, {10'h0, alarms});
        nvm_done_ok <= 1'b1;
        @(posedge clk) nvm_done_ok <= 1'b0;
        nvm_erase_fail <= 1'b1;
        @(posedge clk) nvm_erase_fail <= 1'b0;
        settle();
        check("erase fail", 16'h20, {10'h0, alarms});
    endtask
    // Port 1 is in terminal mode from reset; the terminal stalls meanwhile
    task automatic t_wipe_standby();
        logic [7:0] n0;
        slow <= 1'b1;
        n0 = lf_count;
        cmd(`CMD_SCREEN_WIPE, 1'b1, 8'h00);
        repeat (120) @(posedge clk);
        check("wipe lines", 16'h19, {8'h0, lf_count - n0});
        slow <= 1'b0;
        // Mute line follows the setting one cycle later
        cmd(`CMD_STANDBY, 1'b0, 8'h01);
        @(posedge clk);
        check("warm", 16'h1, {14'h0, xmit_mute_line});
        cmd(`CMD_STANDBY, 1'b0, 8'h00);
        @(posedge clk);
        check("hot", 16'h0, {14'h0, xmit_mute_line});
    endtask
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Hang guard, far beyond the expected several hundred cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            wrap_up();
        end
    end
    initial begin
        {resetn, cmd_valid, cmd_port, cmd_eol, tx_stuck, slow} = 6'h00;
        {nvm_write_fail, nvm_erase_fail, nvm_done_ok} = 3'h0;
        cmd_code = `CMD_NONE;
        cmd_arg = 8'h00;
        flt = 4'h0;
        {cmd_target, str_we, carrier_detect_input, disp_valid} = 4'h0;
        cmd_has_arg = 1'b1;
        cmd_sub = `CMD_NONE;
        {cmd_text_len, pw, str_idx, str_char, disp_char} = 90'h0;
        pkt_in_valid = 2'h0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        t_baud();
        t_lock();
        t_alarms();
        t_manual();
        t_wipe_standby();
        wrap_up();
    end
endmodule // tb_top
